// file: design/periph_access.sv
// Functional notes
// - Set address write forces ones where written.
// - Clear address write forces zeros where written.
// - State address read returns current split bits.
// - Test enable changes only with matching key.
// - Ghost window mirrors reads without side effects.
// - Ghost decoded from address bit thirteen set.
// - Ghost mirror covers every module register.
// - Normal vector read clears normal pending request.
// - Fast vector read clears fast pending request.
// - Converter result read clears conversion done.
// - Serial status read clears idle, ends, lines.
// - Serial holding read clears receive ready.
// - Capture result read clears capture valid.
// - SPI status read clears faults, ends, lines.
// - SPI data read clears receive full.
// - Parallel status read clears all set bits.
// - Capture-mode timer read clears its listed flags.
// - Waveform-mode timer read clears its listed flags.
`timescale 1ns/1ps
`default_nettype none

module periph_access
  import periph_access_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  input  wire logic [FLAG_W-1:0] flagSet,
  input  wire logic              timerWaveMode,
  input  wire logic [DATA_W-1:0] normalVector,
  input  wire logic [DATA_W-1:0] fastVector,
  input  wire logic [DATA_W-1:0] convResult,
  input  wire logic [DATA_W-1:0] serRxData,
  input  wire logic [DATA_W-1:0] captResult,
  input  wire logic [DATA_W-1:0] spiRxData,
  output logic                   rdValid_r,
  output logic      [DATA_W-1:0] rdData_r,
  output logic      [DATA_W-1:0] splitState_r,
  output logic                   testMode_r,
  output logic      [FLAG_W-1:0] flags
);

  flag_if fl ();

  logic              isRead;
  logic              isWrite;
  logic              isGhost;
  logic [OFFS_W-1:0] offs;
  logic [DATA_W-1:0] rdData_nxt;
  logic [FLAG_W-1:0] clrReq;
  logic [TMR_W-1:0]  tmrClrMask;

  // Decode; bit thirteen only selects the side-effect free mirror, offsets are shared.
  assign isRead  = reqValid && !reqWrite;
  assign isWrite = reqValid && reqWrite;
  assign isGhost = reqAddr[GHOST_BIT];
  assign offs    = reqAddr[OFFS_W-1:0];

  // Split register: set and clear ports only touch bits written as one.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      splitState_r <= SPLIT_RST;
    end else if (isWrite && !isGhost && offs == OFF_SPLIT_SET) begin
      splitState_r <= splitState_r | reqWdata;
    end else if (isWrite && !isGhost && offs == OFF_SPLIT_CLR) begin
      splitState_r <= splitState_r & ~reqWdata;
    end
  end

  // Key-protected test enable; a wrong key leaves it untouched, so stray writes are harmless.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      testMode_r <= 1'b0;
    end else if (isWrite && !isGhost && offs == OFF_TEST_MODE
                 && reqWdata[TEST_KEY_LSB +: 16] == TEST_KEY) begin
      testMode_r <= reqWdata[TEST_EN_BIT];
    end
  end

  // Timer clear set depends on the channel mode at the time of the read.
  assign tmrClrMask = timerWaveMode ? TMR_WAVE_CLR : TMR_CAPT_CLR;

  // Read side effects; none from the ghost window so a debugger can look without disturbing.
  always_comb begin
    clrReq = '0;
    if (isRead && !isGhost) begin
      unique case (offs)
        OFF_NIRQ_VEC:  clrReq[IRQ_B + IRQ_NORMAL] = 1'b1;
        OFF_FIRQ_VEC:  clrReq[IRQ_B + IRQ_FAST] = 1'b1;
        OFF_CONV_RES:  clrReq[CONV_B] = 1'b1;
        OFF_SER_STAT:  clrReq[SER_B +: SER_W] = SER_STAT_CLR;
        OFF_SER_RHR:   clrReq[SER_B + SER_RX_READY] = 1'b1;
        OFF_CAPT_RES:  clrReq[CAPT_B] = 1'b1;
        OFF_SPI_STAT:  clrReq[SPI_B +: SPI_W] = SPI_STAT_CLR;
        OFF_SPI_RX_DATA_REG:   clrReq[SPI_B + SPI_RX_FULL] = 1'b1;
        OFF_PIO_STAT:  clrReq[PIO_B +: PIO_W] = {PIO_W{1'b1}};
        OFF_TMR_STAT:  clrReq[TMR_B +: TMR_W] = tmrClrMask;
        default:       clrReq = '0;
      endcase
    end
  end

  assign fl.setEv  = flagSet;
  assign fl.clrReq = clrReq;

  flag_bank uFlags (
    .mclk (mclk),
    .rst  (rst),
    .fl   (fl.bank)
  );

  assign flags = fl.flags;

  // Read mux, shared by normal and ghost windows; unmapped offsets read as zero.
  always_comb begin
    rdData_nxt = '0;
    unique case (offs)
      OFF_SPLIT_STAT: rdData_nxt = splitState_r;
      OFF_TEST_MODE:  rdData_nxt[TEST_EN_BIT] = testMode_r;
      OFF_NIRQ_VEC:   rdData_nxt = normalVector;
      OFF_FIRQ_VEC:   rdData_nxt = fastVector;
      OFF_CONV_RES:   rdData_nxt = convResult;
      OFF_CONV_STAT:  rdData_nxt[CONV_W-1:0] = fl.flags[CONV_B +: CONV_W];
      OFF_SER_STAT:   rdData_nxt[SER_W-1:0] = fl.flags[SER_B +: SER_W];
      OFF_SER_RHR:    rdData_nxt = serRxData;
      OFF_CAPT_RES:   rdData_nxt = captResult;
      OFF_CAPT_STAT:  rdData_nxt[CAPT_W-1:0] = fl.flags[CAPT_B +: CAPT_W];
      OFF_SPI_STAT:   rdData_nxt[SPI_W-1:0] = fl.flags[SPI_B +: SPI_W];
      OFF_SPI_RX_DATA_REG:    rdData_nxt = spiRxData;
      OFF_PIO_STAT:   rdData_nxt = fl.flags[PIO_B +: PIO_W];
      OFF_TMR_STAT:   rdData_nxt[TMR_W-1:0] = fl.flags[TMR_B +: TMR_W];
      default:        rdData_nxt = '0;
    endcase
  end

  // Read answer one cycle after the request; the value is the one before any clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdValid_r <= 1'b0;
      rdData_r  <= RD_RST;
    end else begin
      rdValid_r <= isRead;
      if (isRead) begin
        rdData_r <= rdData_nxt;
      end
    end
  end

endmodule : periph_access

`default_nettype wire

// file: design/periph_access_pkg.sv
package periph_access_pkg;

  // Access port geometry.
  localparam int ADDR_W    = 14;
  localparam int DATA_W    = 32;
  localparam int GHOST_BIT = 13;
  localparam int OFFS_W    = 13;

  // Word offsets inside the peripheral window, as byte addresses.
  localparam logic [12:0] OFF_SPLIT_SET  = 13'h0000;
  localparam logic [12:0] OFF_SPLIT_CLR  = 13'h0004;
  localparam logic [12:0] OFF_SPLIT_STAT = 13'h0008;
  localparam logic [12:0] OFF_TEST_MODE  = 13'h000C;
  localparam logic [12:0] OFF_NIRQ_VEC   = 13'h0010;
  localparam logic [12:0] OFF_FIRQ_VEC   = 13'h0014;
  localparam logic [12:0] OFF_CONV_RES   = 13'h0018;
  localparam logic [12:0] OFF_CONV_STAT  = 13'h001C;
  localparam logic [12:0] OFF_SER_STAT   = 13'h0020;
  localparam logic [12:0] OFF_SER_RHR    = 13'h0024;
  localparam logic [12:0] OFF_CAPT_RES   = 13'h0028;
  localparam logic [12:0] OFF_CAPT_STAT  = 13'h002C;
  localparam logic [12:0] OFF_SPI_STAT   = 13'h0030;
  localparam logic [12:0] OFF_SPI_RX_DATA_REG    = 13'h0034;
  localparam logic [12:0] OFF_PIO_STAT   = 13'h0038;
  localparam logic [12:0] OFF_TMR_STAT   = 13'h003C;

  // Key-protected test register layout.
  localparam int          TEST_KEY_LSB = 16;
  localparam logic [15:0] TEST_KEY     = 16'hD64A;
  localparam int          TEST_EN_BIT  = 1;

  // Reset values.
  localparam logic [31:0] SPLIT_RST = 32'h0000_0000;
  localparam logic [31:0] RD_RST    = 32'h0000_0000;

  // Widths of each flag group.
  localparam int IRQ_W  = 2;
  localparam int CONV_W = 1;
  localparam int SER_W  = 7;
  localparam int CAPT_W = 1;
  localparam int SPI_W  = 12;
  localparam int PIO_W  = 32;
  localparam int TMR_W  = 11;

  // Base of each group in the flat flag vector.
  localparam int IRQ_B  = 0;
  localparam int CONV_B = IRQ_B + IRQ_W;
  localparam int SER_B  = CONV_B + CONV_W;
  localparam int CAPT_B = SER_B + SER_W;
  localparam int SPI_B  = CAPT_B + CAPT_W;
  localparam int PIO_B  = SPI_B + SPI_W;
  localparam int TMR_B  = PIO_B + PIO_W;
  localparam int FLAG_W = TMR_B + TMR_W;

  // Interrupt controller pending bits.
  localparam int IRQ_NORMAL = 0;
  localparam int IRQ_FAST   = 1;

  // Serial status bits.
  localparam int SER_RX_READY = 0;
  localparam int SER_RX_END   = 1;
  localparam int SER_TX_END   = 2;
  localparam int SER_IDLE     = 3;
  localparam int SER_SCK_LVL  = 4;
  localparam int SER_TXD_LVL  = 5;
  localparam int SER_RXD_LVL  = 6;
  localparam logic [SER_W-1:0] SER_STAT_CLR = 7'h7E;

  // SPI status bits; bits 8 to 11 are chip selects 0 to 3.
  localparam int SPI_RX_FULL  = 0;
  localparam int SPI_MODE_FLT = 1;
  localparam int SPI_OVERRUN  = 2;
  localparam int SPI_RX_END   = 3;
  localparam int SPI_TX_END   = 4;
  localparam int SPI_SPCK_LVL = 5;
  localparam int SPI_MISO_LVL = 6;
  localparam int SPI_MOSI_LVL = 7;
  localparam int SPI_CS0_LVL  = 8;
  localparam logic [SPI_W-1:0] SPI_STAT_CLR = 12'hFFE;

  // Timer status bits.
  localparam int TMR_OVF   = 0;
  localparam int TMR_LOVR  = 1;
  localparam int TMR_CMPA  = 2;
  localparam int TMR_CMPB  = 3;
  localparam int TMR_CMPC  = 4;
  localparam int TMR_LDA   = 5;
  localparam int TMR_LDB   = 6;
  localparam int TMR_ETRG  = 7;
  localparam int TMR_PINA  = 8;
  localparam int TMR_PINB  = 9;
  localparam int TMR_CLKIN = 10;
  localparam logic [TMR_W-1:0] TMR_CAPT_CLR = 11'h7F3;
  localparam logic [TMR_W-1:0] TMR_WAVE_CLR = 11'h79D;

endpackage : periph_access_pkg

// file: design/flag_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries hardware set events and read clears to the flag bank, and the flags back.
interface flag_if;
  import periph_access_pkg::*;
  logic [FLAG_W-1:0] setEv;
  logic [FLAG_W-1:0] clrReq;
  logic [FLAG_W-1:0] flags;
  modport bank (input setEv, input clrReq, output flags);
  modport user (output setEv, output clrReq, input flags);
endinterface : flag_if

`default_nettype wire

// file: design/flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

module flag_bank
  import periph_access_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  flag_if.bank      fl
);

  // One sticky flag per bit; a set in the same cycle as a clear wins so no event is lost.
  for (genvar i = 0; i < FLAG_W; i++) begin : gFlag
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        fl.flags[i] <= 1'b0;
      end else if (fl.setEv[i]) begin
        fl.flags[i] <= 1'b1;
      end else if (fl.clrReq[i]) begin
        fl.flags[i] <= 1'b0;
      end
    end
  end

endmodule : flag_bank

`default_nettype wire

// file: bench/periph_access_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module periph_access_assertions
  import periph_access_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              reqValid,
  input wire logic              reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqWdata,
  input wire logic [FLAG_W-1:0] flagSet,
  input wire logic              rdValid_r,
  input wire logic [DATA_W-1:0] splitState_r,
  input wire logic              testMode_r,
  input wire logic [FLAG_W-1:0] flags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Ghost writes are dropped, so only normal-window writes may move state.
  wire logic        rd  = reqValid && !reqWrite;
  wire logic        wr  = reqValid && reqWrite && !reqAddr[GHOST_BIT];
  wire logic [12:0] off = reqAddr[12:0];
  wire logic        nz  = flagSet == '0;
  a_read_answer:
    assert property (rd |=> rdValid_r) else $error("read not answered");
  a_no_spurious:
    assert property (!rd |=> !rdValid_r) else $error("answer without read");
  a_split_set:
    assert property (wr && off == OFF_SPLIT_SET |=> splitState_r == ($past(splitState_r) | $past(reqWdata)))
      else $error("set write wrong");
  a_split_clr:
    assert property (wr && off == OFF_SPLIT_CLR |=> splitState_r == ($past(splitState_r) & ~$past(reqWdata)))
      else $error("clear write wrong");
  a_split_hold:
    assert property (!(wr && (off == OFF_SPLIT_SET || off == OFF_SPLIT_CLR)) |=> $stable(splitState_r))
      else $error("split state moved");
  a_key_guard:
    assert property (!(wr && off == OFF_TEST_MODE && reqWdata[31:16] == TEST_KEY) |=> $stable(testMode_r))
      else $error("test mode moved without key");
  a_key_write:
    assert property (wr && off == OFF_TEST_MODE && reqWdata[31:16] == TEST_KEY |=> testMode_r == $past(reqWdata[1]))
      else $error("keyed write ignored");
  a_ghost_quiet:
    assert property (rd && reqAddr[GHOST_BIT] && nz |=> flags == $past(flags)) else $error("ghost read cleared");
  a_pio_clear:
    assert property (rd && !reqAddr[GHOST_BIT] && off == OFF_PIO_STAT && nz |=> flags[PIO_B+:PIO_W] == '0)
      else $error("pio status kept");
  a_normal_clear:
    assert property (rd && !reqAddr[GHOST_BIT] && off == OFF_NIRQ_VEC && nz |=> !flags[IRQ_B])
      else $error("normal request kept");
endmodule : periph_access_assertions
`default_nettype wire

// file: bench/sw_master.sv
`timescale 1ns/1ps
`default_nettype none
module sw_master
  import periph_access_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rdValid_r,
  input  wire logic [DATA_W-1:0] rdData_r,
  output logic                   reqValid,
  output logic                   reqWrite,
  output logic      [ADDR_W-1:0] reqAddr,
  output logic      [DATA_W-1:0] reqWdata
);
  initial {reqValid, reqWrite, reqAddr, reqWdata} = '0;
  // One access per call; released lines are inverted so stale values never look valid.
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    @(negedge mclk);
    {reqValid, reqWrite, reqAddr, reqWdata} = {1'b1, w, a, d};
    @(negedge mclk);
    reqValid = 1'b0;
    {reqWrite, reqAddr, reqWdata} = ~{reqWrite, reqAddr, reqWdata};
    q = rdValid_r ? rdData_r : 32'hBAD0_BAD0;
  endtask : access
endmodule : sw_master
`default_nettype wire

// file: bench/test_peripheral_register_access_rules.sv
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_register_access_rules
  import periph_access_pkg::*;
;
  typedef struct {logic [1:0] k; logic [13:0] a; logic [31:0] d, e; logic [65:0] c;} row_t;
  logic              mclk = 1'b0, rst = 1'b1, timerWaveMode = 1'b0, reqValid, reqWrite, rdValid_r, testMode_r;
  logic [ADDR_W-1:0] reqAddr;
  logic [DATA_W-1:0] reqWdata, rdData_r, splitState_r, q;
  logic [FLAG_W-1:0] flagSet = '0, flags;
  // The SPI receive word comes from a bench variable, so the read path is not fed by a tied constant alone.
  logic [DATA_W-1:0] spiRx = 32'h0000_5A06;
  int                err_count = 0, checks_done = 0, cyc = 0;
  // Field k: bit 1 write, bit 0 waveform mode; c holds the flags a read should clear.
  row_t rows[18] = '{
    '{2'h2, 14'h0000, 32'h0005_0000, '0, '0}, '{2'h0, 14'h0008, '0, 32'h0005_0000, '0},
    '{2'h2, 14'h0004, 32'h0004_0000, '0, '0}, '{2'h2, 14'h2000, 32'hFFFF_FFFF, '0, '0},
    '{2'h0, 14'h2008, '0, 32'h0001_0000, '0}, '{2'h0, 14'h0010, '0, 32'h0000_5A01, 66'h1},
    '{2'h0, 14'h0014, '0, 32'h0000_5A02, 66'h2}, '{2'h0, 14'h0018, '0, 32'h0000_5A03, 66'h4},
    '{2'h0, 14'h001C, '0, 32'h0000_0001, '0}, '{2'h0, 14'h0020, '0, 32'h0000_007F, 66'h3F0},
    '{2'h0, 14'h0024, '0, 32'h0000_5A04, 66'h8}, '{2'h0, 14'h0028, '0, 32'h0000_5A05, 66'h400},
    '{2'h0, 14'h0030, '0, 32'h0000_0FFF, 66'h7F_F000}, '{2'h0, 14'h0034, '0, 32'h0000_5A06, 66'h800},
    '{2'h0, 14'h0038, '0, 32'hFFFF_FFFF, 66'h7F_FFFF_FF80_0000},
    '{2'h0, 14'h003C, '0, 32'h0000_07FF, 66'h3_F980_0000_0000_0000},
    '{2'h1, 14'h003C, '0, 32'h0000_07FF, 66'h3_CE80_0000_0000_0000},
    '{2'h0, 14'h203C, '0, 32'h0000_07FF, '0}};
  periph_access uut (.mclk(mclk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .flagSet(flagSet), .timerWaveMode(timerWaveMode), .normalVector(32'h0000_5A01),
    .fastVector(32'h0000_5A02), .convResult(32'h0000_5A03), .serRxData(32'h0000_5A04),
    .captResult(32'h0000_5A05), .spiRxData(spiRx), .rdValid_r(rdValid_r), .rdData_r(rdData_r),
    .splitState_r(splitState_r), .testMode_r(testMode_r), .flags(flags));
  sw_master sw (.mclk(mclk), .rdValid_r(rdValid_r), .rdData_r(rdData_r), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata));
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [65:0] s, input logic [65:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // Cuts a hang short; the whole run needs fewer than a hundred cycles.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      give_verdict();
    end
  end
  // Every row first sets all flags, so each read shows exactly which flags it clears.
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    foreach (rows[i]) begin
      flagSet = '1;
      timerWaveMode = rows[i].k[0];
      @(negedge mclk);
      flagSet = '0;
      sw.access(rows[i].k[1], rows[i].a, rows[i].d, q);
      if (!rows[i].k[1]) chk(q, rows[i].e);
      chk(flags, ~rows[i].c);
      $display("row %0d done", i);
    end
    sw.access(1'b1, 14'h000C, 32'hD64B_0002, q);
    chk(testMode_r, 66'h0);
    sw.access(1'b1, 14'h000C, 32'hD64A_0002, q);
    chk(testMode_r, 66'h1);
    sw.access(1'b1, 14'h200C, 32'hD64A_0000, q);
    chk(testMode_r, 66'h1);
    sw.access(1'b1, 14'h000C, 32'hD64A_0000, q);
    chk(testMode_r, 66'h0);
    $display("key test done");
    spiRx = 32'hA5C3_0F96;
    sw.access(1'b0, 14'h2034, '0, q);
    chk(q, 66'hA5C3_0F96);
    flagSet = '1;
    @(negedge mclk);
    flagSet = '0;
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    chk(flags, 66'h0);
    chk(splitState_r, 66'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule : test_peripheral_register_access_rules
bind periph_access periph_access_assertions chk_i (.mclk(mclk), .rst(rst), .reqValid(reqValid),
  .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .flagSet(flagSet), .rdValid_r(rdValid_r),
  .splitState_r(splitState_r), .testMode_r(testMode_r), .flags(flags));
`default_nettype wire
